// ===== hdl/supervisor_params.svh
// Constants of the supply supervisor and watchdog: timing, select codes, register map.
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define T_RST_MS 200
`define T_INIT_US 390
`define T_WD_SETUP_US 140
`define T_WD_FLOAT_MS 1600
`define T_WD_PULLUP_MS 200
`define RST_CYCLES ((64'd`T_RST_MS * 64'd1000000 + 64'd`CLK_PERIOD_NS - 64'd1) / 64'd`CLK_PERIOD_NS)
`define INIT_CYCLES ((64'd`T_INIT_US * 64'd1000 + 64'd`CLK_PERIOD_NS - 64'd1) / 64'd`CLK_PERIOD_NS)
`define SETUP_CYCLES ((64'd`T_WD_SETUP_US * 64'd1000 + 64'd`CLK_PERIOD_NS - 64'd1) / 64'd`CLK_PERIOD_NS)
`define WD_FLOAT_CYCLES ((64'd`T_WD_FLOAT_MS * 64'd1000000) / 64'd`CLK_PERIOD_NS)
`define WD_PULLUP_CYCLES ((64'd`T_WD_PULLUP_MS * 64'd1000000) / 64'd`CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Timeout select codes
// ----------------------------------------------------------------------------
`define SRC_FLOAT 2'h0
`define SRC_PULLUP 2'h1
`define SRC_CAP 2'h2

// ----------------------------------------------------------------------------
// Pin synchroniser reset levels
// ----------------------------------------------------------------------------
// Manual reset high and driven, kick at its idle high level, all others low.
`define PIN_SYNC_INIT 8'h1c

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define REG_STATUS 6'h00
`define REG_ADJ_TIMEOUT 6'h01
`define ADJ_TIMEOUT_RESET 32'h000f_4240
`define ST_RELEASED_BIT 0
`define ST_FAULT_BIT 1
`define ST_SRC_LSB 2
`define ST_SRC_VALID_BIT 4
`define ST_WD_RUN_BIT 5
`define ST_ENABLE_BIT 6

`endif

// ===== hdl/supervisor_pkg.sv
// Types shared by the supply supervisor and watchdog.
package supervisor_pkg;
    typedef enum logic [1:0] {RST_HOLD, RST_DELAY, RST_RUN} rst_state_t;
    typedef enum logic [1:0] {WD_OFF, WD_SETUP, WD_RUN, WD_FAULT} wd_state_t;
endpackage

// ===== hdl/supervisor_reset_watchdog.sv
// Supply supervisor with reset release delay, watchdog timer and Wishbone status registers.
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
`include "supervisor_params.svh"
module supervisor_reset_watchdog #(
    parameter logic [31:0] RST_CYC = 32'(`RST_CYCLES),
    parameter logic [31:0] INIT_CYC = 32'(`INIT_CYCLES),
    parameter logic [31:0] SETUP_CYC = 32'(`SETUP_CYCLES),
    parameter logic [31:0] WD_FLOAT_CYC = 32'(`WD_FLOAT_CYCLES),
    parameter logic [31:0] WD_PULLUP_CYC = 32'(`WD_PULLUP_CYCLES)
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic supply_good,
    input wire logic supply_min_ok,
    input wire logic manual_reset_in,
    input wire logic manual_reset_driven,
    input wire logic watchdog_kick_in,
    input wire logic watchdog_enable_in,
    input wire logic [1:0] timeout_select_pin,
    output logic system_reset_out,
    output logic system_reset_oe,
    output logic watchdog_fault_out,
    output logic watchdog_fault_oe,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import supervisor_pkg::*;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [7:0] pins_s;
    logic supply_s, min_s, mr_pin_s, mr_drv_s, kick_s, enable_s;
    logic [1:0] sel_s;
    logic kick_d_r, kick_fall, mr_eff;

    // The kick bit resets to its idle high level so that no false edge follows reset.
    sync_two_stage #(.WIDTH(8), .INIT(`PIN_SYNC_INIT)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in({timeout_select_pin, watchdog_enable_in, watchdog_kick_in,
                   manual_reset_driven, manual_reset_in, supply_min_ok, supply_good}),
        .sync_out(pins_s)
    );

    assign {sel_s, enable_s, kick_s, mr_drv_s, mr_pin_s, min_s, supply_s} = pins_s;

    // An undriven manual reset pin reads as released through the pull-up.
    assign mr_eff = mr_pin_s | ~mr_drv_s;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            kick_d_r <= 1'b1;
        end else begin
            kick_d_r <= kick_s;
        end
    end

    // Only a high-to-low change of the kick pin counts.
    assign kick_fall = kick_d_r & ~kick_s;

    // ------------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------------
    rst_state_t rst_state_r;
    rst_state_t rst_state_nxt;
    logic [31:0] rst_cnt_r;
    logic hold_req, rst_run_nxt;

    // Low supply, supply under the minimum, or manual reset all hold reset.
    assign hold_req = ~(supply_s & min_s) | ~mr_eff;

    always_comb begin
        rst_state_nxt = rst_state_r;
        if (hold_req) begin
            rst_state_nxt = RST_HOLD;
        end else begin
            unique case (rst_state_r)
                RST_HOLD: rst_state_nxt = RST_DELAY;
                RST_DELAY: begin
                    if (rst_cnt_r >= RST_CYC - 32'h1) begin
                        rst_state_nxt = RST_RUN;
                    end
                end
                RST_RUN: rst_state_nxt = RST_RUN;
            endcase
        end
    end

    assign rst_run_nxt = (rst_state_nxt == RST_RUN);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_state_r <= RST_HOLD;
        end else begin
            rst_state_r <= rst_state_nxt;
        end
    end

    // The delay count restarts whenever the hold condition returns.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_cnt_r <= 32'h0;
        end else if (rst_state_r == RST_DELAY && !hold_req) begin
            rst_cnt_r <= rst_cnt_r + 32'h1;
        end else begin
            rst_cnt_r <= 32'h0;
        end
    end

    // Open-drain reset pin: driven low while held, released otherwise.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            system_reset_out <= 1'b0;
            system_reset_oe <= 1'b1;
        end else begin
            system_reset_out <= rst_run_nxt;
            system_reset_oe <= ~rst_run_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Timeout source evaluation
    // ------------------------------------------------------------------------
    logic eval_active_r;
    logic [31:0] eval_cnt_r;
    logic [1:0] src_r;
    logic src_valid_r, eval_done;

    assign eval_done = eval_active_r && (eval_cnt_r >= INIT_CYC - 32'h1);

    // The window opens as the supply recovers and the release delay starts.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            eval_active_r <= 1'b0;
            eval_cnt_r <= 32'h0;
        end else if (hold_req) begin
            eval_active_r <= 1'b0;
            eval_cnt_r <= 32'h0;
        end else if (rst_state_r == RST_HOLD) begin
            eval_active_r <= 1'b1;
            eval_cnt_r <= 32'h0;
        end else if (eval_done) begin
            eval_active_r <= 1'b0;
            eval_cnt_r <= 32'h0;
        end else if (eval_active_r) begin
            eval_cnt_r <= eval_cnt_r + 32'h1;
        end
    end

    // The source is latched at the end of the window and held until the next window ends; a hold clears only its valid flag, nrst also loads SRC_FLOAT.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            src_r <= `SRC_FLOAT;
            src_valid_r <= 1'b0;
        end else if (hold_req) begin
            src_valid_r <= 1'b0;
        end else if (eval_done) begin
            src_r <= (sel_s == `SRC_PULLUP || sel_s == `SRC_CAP) ? sel_s : `SRC_FLOAT;
            src_valid_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------------
    logic [31:0] adj_timeout_r;
    logic wb_req;
    logic [5:0] wb_idx;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_idx = wb_adr_i[7:2];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            adj_timeout_r <= `ADJ_TIMEOUT_RESET;
        end else if (wb_req && wb_we_i && wb_idx == `REG_ADJ_TIMEOUT) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    adj_timeout_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Watchdog timer
    // ------------------------------------------------------------------------
    wd_state_t wd_state_r;
    wd_state_t wd_state_nxt;
    logic [31:0] wd_cnt_r;
    logic [31:0] tmo_cyc;
    logic [31:0] tmo_last;
    logic wd_en;
    logic tmo_hit;

    // Capacitor mode takes its count from software; factory modes are fixed.
    always_comb begin
        tmo_cyc = WD_FLOAT_CYC;
        if (src_r == `SRC_PULLUP) begin
            tmo_cyc = WD_PULLUP_CYC;
        end else if (src_r == `SRC_CAP) begin
            tmo_cyc = adj_timeout_r;
        end
    end

    assign tmo_last = (tmo_cyc == 32'h0) ? 32'h0 : tmo_cyc - 32'h1;
    assign tmo_hit = (wd_cnt_r >= tmo_last);

    // The timer runs only with reset released, enable high and a locked source.
    assign wd_en = rst_run_nxt & enable_s & src_valid_r;

    always_comb begin
        wd_state_nxt = wd_state_r;
        if (!wd_en) begin
            wd_state_nxt = WD_OFF;
        end else begin
            unique case (wd_state_r)
                WD_OFF: wd_state_nxt = WD_SETUP;
                WD_SETUP: begin
                    if (wd_cnt_r >= SETUP_CYC - 32'h1) begin
                        wd_state_nxt = WD_RUN;
                    end
                end
                WD_RUN: begin
                    if (!kick_fall && tmo_hit) begin
                        wd_state_nxt = WD_FAULT;
                    end
                end
                WD_FAULT: begin
                    if (wd_cnt_r >= RST_CYC - 32'h1) begin
                        wd_state_nxt = WD_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wd_state_r <= WD_OFF;
        end else begin
            wd_state_r <= wd_state_nxt;
        end
    end

    // A kick in time restarts the interval; kicks in set-up or fault are ignored.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wd_cnt_r <= 32'h0;
        end else if (wd_state_nxt != wd_state_r) begin
            wd_cnt_r <= 32'h0;
        end else if (wd_state_r == WD_RUN && kick_fall) begin
            wd_cnt_r <= 32'h0;
        end else if (wd_state_r != WD_OFF) begin
            wd_cnt_r <= wd_cnt_r + 32'h1;
        end else begin
            wd_cnt_r <= 32'h0;
        end
    end

    // Open-drain fault pin: low only during a fault pulse, released otherwise.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            watchdog_fault_out <= 1'b1;
            watchdog_fault_oe <= 1'b0;
        end else begin
            watchdog_fault_out <= (wd_state_nxt != WD_FAULT);
            watchdog_fault_oe <= (wd_state_nxt == WD_FAULT);
        end
    end

    // ------------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------------
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h0;
        status_word[`ST_RELEASED_BIT] = system_reset_out;
        status_word[`ST_FAULT_BIT] = ~watchdog_fault_out;
        status_word[`ST_SRC_LSB +: 2] = src_r;
        status_word[`ST_SRC_VALID_BIT] = src_valid_r;
        status_word[`ST_WD_RUN_BIT] = (wd_state_r == WD_RUN);
        status_word[`ST_ENABLE_BIT] = enable_s;
    end

    // Every access is acknowledged one cycle later; unmapped reads return zero.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                if (wb_idx == `REG_STATUS) begin
                    wb_dat_o <= status_word;
                end else if (wb_idx == `REG_ADJ_TIMEOUT) begin
                    wb_dat_o <= adj_timeout_r;
                end else begin
                    wb_dat_o <= 32'h0;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_timeout_hit;
        wd_state_r == WD_RUN && !kick_fall && tmo_hit && wd_en;
    endsequence
    sequence s_fault_pulse;
        !watchdog_fault_out && watchdog_fault_oe;
    endsequence

    a_uv_holds_reset: assert property (
        !supply_s |=> !system_reset_out && system_reset_oe)
        else $error("reset not asserted with low supply");
    a_mr_holds_reset: assert property (
        !mr_pin_s && mr_drv_s |=> !system_reset_out)
        else $error("reset not asserted by manual reset");
    a_release_after_delay: assert property (
        $rose(system_reset_out) |-> $past(rst_cnt_r) == RST_CYC - 32'h1)
        else $error("reset released before the full delay");
    a_release_conditions: assert property (
        $rose(system_reset_out) |-> $past(supply_s) && $past(mr_eff) && $past(min_s))
        else $error("reset released while a hold condition stood");
    a_fault_hiz_in_reset: assert property (
        !system_reset_out |-> !watchdog_fault_oe && watchdog_fault_out)
        else $error("fault pin driven while reset asserted");
    a_timeout_fault: assert property (
        s_timeout_hit |=> s_fault_pulse)
        else $error("missing kick did not start the fault pulse");
    a_fault_not_reset: assert property (
        s_fault_pulse ##0 supply_s && min_s && mr_eff |=> system_reset_out)
        else $error("watchdog fault caused a system reset");
    a_disable_off: assert property (
        !enable_s |=> wd_state_r == WD_OFF && watchdog_fault_out)
        else $error("watchdog active while disabled");
    a_setup_length: assert property (
        $rose(wd_state_r == WD_RUN) && $past(wd_state_r) == WD_SETUP
        |-> $past(wd_cnt_r) == SETUP_CYC - 32'h1)
        else $error("set-up interval length wrong");
    a_kick_restarts: assert property (
        wd_state_r == WD_RUN && kick_fall && wd_en |=> wd_state_r == WD_RUN && wd_cnt_r == 32'h0)
        else $error("kick did not restart the interval");
    a_source_locked: assert property (
        $changed(src_r) |-> $past(eval_done))
        else $error("timeout source changed outside the evaluation window");
    a_reset_kills_wd: assert property (
        !system_reset_out |-> wd_state_r == WD_OFF)
        else $error("watchdog running while reset asserted");

endmodule

// ===== hdl/sync_two_stage.sv
// Two flip-flop synchroniser for a vector of asynchronous pins.
`timescale 1ns/100ps
module sync_two_stage #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= INIT;
            sync_out <= INIT;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ===== sim/host_kicker.sv
// Host processor model that kicks the watchdog with falling edges at a set period.
`timescale 1ns/100ps
module host_kicker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [7:0] period,
    output logic kick
);
    logic [7:0] cnt_r;

    // ------------------------------------------------------------------
    // Kick generator
    // ------------------------------------------------------------------
    // The line rests high when idle, so no falling edge is ever seen then.
    // Each level lasts at least three cycles for any period of eight or more.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 8'h00;
            kick <= 1'b1;
        end else if (!run) begin
            cnt_r <= 8'h00;
            kick <= 1'b1;
        end else if (cnt_r >= period - 8'h01) begin
            cnt_r <= 8'h00;
            kick <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == (period >> 1)) begin
                kick <= 1'b1;
            end
        end
    end
endmodule

// ===== sim/tb_supervisor_reset_watchdog.sv
// Self-checking bench for the supply supervisor and watchdog.
`timescale 1ns/100ps
module tb_supervisor_reset_watchdog;
    localparam logic [31:0] RST = 32'h0000_0028;
    localparam logic [31:0] SETUP = 32'h0000_0008;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic supply_good = 1'b0;
    logic supply_min_ok = 1'b0;
    logic manual_reset_in = 1'b1;
    logic manual_reset_driven = 1'b1;
    logic watchdog_kick_in;
    logic watchdog_enable_in = 1'b1;
    logic [1:0] timeout_select_pin = 2'h1;
    logic system_reset_out, system_reset_oe, watchdog_fault_out, watchdog_fault_oe;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic kick_run = 1'b0;
    logic [7:0] kick_period = 8'h0a;
    logic [31:0] rd;
    integer seed = 32'hc1d55f60;
    int errors = 0;
    int checks = 0;
    int n, f, r, t, adj;

    always #5 clk = ~clk;

    supervisor_reset_watchdog #(.RST_CYC(RST), .INIT_CYC(32'h0000_000a), .SETUP_CYC(SETUP),
        .WD_FLOAT_CYC(32'h0000_003c), .WD_PULLUP_CYC(32'h0000_001e)) DUT (
        .clk(clk), .nrst(nrst), .supply_good(supply_good), .supply_min_ok(supply_min_ok),
        .manual_reset_in(manual_reset_in), .manual_reset_driven(manual_reset_driven),
        .watchdog_kick_in(watchdog_kick_in), .watchdog_enable_in(watchdog_enable_in),
        .timeout_select_pin(timeout_select_pin), .system_reset_out(system_reset_out),
        .system_reset_oe(system_reset_oe), .watchdog_fault_out(watchdog_fault_out),
        .watchdog_fault_oe(watchdog_fault_oe), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

    host_kicker host (.clk(clk), .nrst(nrst), .run(kick_run), .period(kick_period),
        .kick(watchdog_kick_in));

    // ------------------------------------------------------------------
    // Expectations and helpers
    // ------------------------------------------------------------------
    // Select code 3 is not a defined source and falls back to the floating timeout.
    function automatic int tmo_of(input logic [1:0] s, input int adj_cyc);
        return (s == 2'h1) ? 30 : (s == 2'h2) ? adj_cyc : 60;
    endfunction

    function automatic logic [31:0] status_of(input logic [1:0] s, input logic run_st);
        return {25'h0, 1'b1, run_st, 1'b1, s, 1'b0, 1'b1};
    endfunction

    task automatic end_sim();
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic bail(input string name);
        errors++;
        $display("ERROR %s expected response seen timeout", name);
        end_sim();
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Waits for reset output (k=0) or fault enable (k=1) to reach a level.
    task automatic wait_sig(input bit k, input logic v, input int bound, output int cnt);
        cnt = 0;
        while ((k ? watchdog_fault_oe : system_reset_out) !== v) begin
            @(posedge clk);
            cnt++;
            if (cnt > bound) bail("wait_level");
        end
    endtask

    task automatic watch(input int len, output int fc, output int rc);
        fc = 0;
        rc = 0;
        repeat (len) begin
            @(posedge clk);
            fc += int'(watchdog_fault_oe !== 1'b0);
            rc += int'(system_reset_out !== 1'b1);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] q);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        do begin
            @(posedge clk);
            k++;
            if (k > 20) bail("wb_ack");
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        watch(10, f, r);
        check("fault_oe_low_supply", f, 0);
        check("reset_below_min", r, 10);
        check("reset_oe_hold", system_reset_oe, 1'b1);
        supply_min_ok <= 1'b1;
        watch(10, f, r);
        check("reset_undervoltage", r, 10);
        supply_good <= 1'b1;
        wait_sig(0, 1'b1, 60, n);
        check("release_delay", n >= RST && n <= RST + 6, 1);
        check("reset_oe_free", system_reset_oe, 1'b0);
        kick_run <= 1'b1;
        repeat (6) begin
            kick_period <= 8'h08 + 8'($unsigned($random(seed)) % 8);
            watch(100, f, r);
            check("fault_with_kicks", f, 0);
            check("reset_kept", r, 0);
        end
        wb(1'b0, 8'h00, 32'h0000_0000, rd);
        check("status", rd, status_of(2'h1, 1'b1));
        wb(1'b0, 8'h04, 32'h0000_0000, rd);
        check("adj_reset", rd, 32'h000f_4240);
        wb(1'b1, 8'h08, 32'hffff_ffff, rd);
        wb(1'b0, 8'h08, 32'h0000_0000, rd);
        check("unmapped", rd, 32'h0000_0000);
        kick_run <= 1'b0;
        wait_sig(1, 1'b1, 40, n);
        check("fault_level", watchdog_fault_out, 1'b0);
        wait_sig(1, 1'b0, RST + 4, n);
        check("fault_pulse", n >= RST && n <= RST + 1, 1);
        check("reset_after_fault", system_reset_out, 1'b1);
        watchdog_enable_in <= 1'b0;
        watch(120, f, r);
        check("fault_disabled", f, 0);
        watchdog_enable_in <= 1'b1;
        repeat (5) @(posedge clk);
        wb(1'b0, 8'h00, 32'h0000_0000, rd);
        check("setup_run_bit", rd[5], 1'b0);
        repeat (SETUP + 6) @(posedge clk);
        wb(1'b0, 8'h00, 32'h0000_0000, rd);
        check("run_bit", rd[5], 1'b1);
        adj = 90 + int'($unsigned($random(seed)) % 32);
        wb(1'b1, 8'h04, 32'(adj), rd);
        wb(1'b0, 8'h04, 32'h0000_0000, rd);
        check("adj_write", rd, 32'(adj));
        for (int s = 0; s < 4; s++) begin
            timeout_select_pin <= 2'(s);
            manual_reset_in <= 1'b0;
            wait_sig(0, 1'b0, 6, n);
            check("fault_released", watchdog_fault_oe, 1'b0);
            manual_reset_in <= 1'b1;
            wait_sig(0, 1'b1, RST + 8, n);
            check("manual_release", n >= RST && n <= RST + 6, 1);
            timeout_select_pin <= 2'h3;
            t = tmo_of(2'(s), adj) + SETUP;
            wait_sig(1, 1'b1, 140, n);
            check("timeout", n >= t && n <= t + 6, 1);
            wb(1'b0, 8'h00, 32'h0000_0000, rd);
            check("source_locked", rd[3:2], (s == 3) ? 2'h0 : 2'(s));
        end
        manual_reset_driven <= 1'b0;
        manual_reset_in <= 1'b0;
        watch(20, f, r);
        check("floating_manual", r, 0);
        supply_good <= 1'b0;
        wait_sig(0, 1'b0, 6, n);
        check("fault_oe_uv", watchdog_fault_oe, 1'b0);
        supply_min_ok <= 1'b0;
        supply_good <= 1'b1;
        watch(60, f, r);
        check("min_supply_hold", r, 60);
        check("min_supply_fault", f, 0);
        end_sim();
    end
endmodule
